/* File: hdl/icf_capture.sv */
// icf_capture: input capture unit with control fields, result buffer
// and interrupt status. assumes timers and low-power level on clk_in.
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE_01: timer source 0 captures third timer, 1 captures second timer.
// RULE_02: interval field 00..11 raises interrupt every 1st..4th capture.
// RULE_03: overflow bit 4 is read-only, set once an overflow occurred.
// RULE_04: bit 3 read-only, high while buffer holds unread values.
// RULE_05: mode 111 interrupts on rising edge only in sleep or idle.
// RULE_06: mode 110 captures configured first edge, then every edge.
// RULE_07: mode 101 captures every sixteenth rising edge.
// RULE_08: mode 100 captures every fourth rising edge.
// RULE_09: mode 011 captures every rising edge.
// RULE_10: mode 010 captures every falling edge.
// RULE_11: edge-detect mode captures on every transition.
// RULE_12: mode 000 disables capture.
// RULE_13: wide capture ignores the timer source field.
// RULE_14: clearing enable clears overflow, buffer, event and prescale counts.
// RULE_15: disabled mode takes no captures; buffer readable; prescaler runs.
// RULE_16: mode code 001 is edge-detect mode.
// RULE_17: capture into full buffer sets overflow and drops the value.
module icf_capture
    import icf_pkg::*;
#(
    parameter int DEPTH   = 4,
    parameter int TIMER_W = 16
) (
    // clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    input  wire logic                 ce_in,
    // register port
    input  wire logic [7:0]           addr_in,
    input  wire logic [31:0]          wr_data_in,
    input  wire logic                 wr_en_in,
    input  wire logic                 rd_en_in,
    output logic      [31:0]          rd_data_out,
    // capture sources
    input  wire logic                 cap_pin_in,
    input  wire logic [TIMER_W-1:0]   second_timer_in,
    input  wire logic [TIMER_W-1:0]   third_timer_in,
    input  wire logic                 low_power_in,
    // interrupt
    output logic                      irq_out
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = PTR_W + 1;
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

    // ==========================================================
    // pin synchroniser and filtered level
    logic [2:0] pin_sync;
    logic [2:0] next_pin_sync;
    logic       pin_level;
    logic       next_pin_level;
    logic       pin_change;
    logic       pin_rise;
    logic       pin_fall;

    always_comb begin
        next_pin_sync  = {pin_sync[1:0], cap_pin_in};
        // level moves only once stages two and three agree
        pin_change     = (pin_sync[1] == pin_sync[2]) && (pin_sync[2] != pin_level);
        pin_rise       = pin_change && pin_sync[2];
        pin_fall       = pin_change && !pin_sync[2];
        next_pin_level = pin_change ? pin_sync[2] : pin_level;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_sync  <= 3'h0;
            pin_level <= 1'b0;
        end else if (ce_in) begin
            pin_sync  <= next_pin_sync;
            pin_level <= next_pin_level;
        end
    end

    // ==========================================================
    // capture state
    icf_ctrl_t                 ctrl;
    icf_ctrl_t                 next_ctrl;
    logic                      overflow;
    logic                      next_overflow;
    logic [2*TIMER_W-1:0]      fifo_mem [DEPTH];
    logic [2*TIMER_W-1:0]      next_fifo_mem [DEPTH];
    logic [PTR_W-1:0]          wr_ptr;
    logic [PTR_W-1:0]          next_wr_ptr;
    logic [PTR_W-1:0]          rd_ptr;
    logic [PTR_W-1:0]          next_rd_ptr;
    logic [CNT_W-1:0]          fill;
    logic [CNT_W-1:0]          next_fill;
    logic [3:0]                prescale;
    logic [3:0]                next_prescale;
    logic [1:0]                event_cnt;
    logic [1:0]                next_event_cnt;
    logic                      first_done;
    logic                      next_first_done;
    logic [ICF_IRQ_W-1:0]      irq_status;
    logic [ICF_IRQ_W-1:0]      next_irq_status;
    logic [ICF_IRQ_W-1:0]      irq_enable;
    logic [ICF_IRQ_W-1:0]      next_irq_enable;
    logic [31:0]               next_rd_data;
    logic                      next_irq;

    logic                      capture_hit;
    logic                      pop;
    logic                      push;
    logic                      full_now;
    logic [2*TIMER_W-1:0]      stamp;
    logic [ICF_IRQ_W-1:0]      irq_set;
    logic [ICF_IRQ_W-1:0]      irq_clr;
    logic [31:0]               ctrl_word;

    always_comb begin
        next_ctrl       = ctrl;
        next_overflow   = overflow;
        next_fifo_mem   = fifo_mem;
        next_wr_ptr     = wr_ptr;
        next_rd_ptr     = rd_ptr;
        next_fill       = fill;
        next_prescale   = prescale;
        next_event_cnt  = event_cnt;
        next_first_done = first_done;
        next_irq_enable = irq_enable;
        irq_set         = '0;
        irq_clr         = '0;
        push            = 1'b0;

        // wide capture: second timer low half, third timer high half
        if (ctrl.wide) begin
            stamp = {third_timer_in, second_timer_in}; // RULE_13
        end else if (ctrl.timer_sel) begin
            stamp = {{TIMER_W{1'b0}}, second_timer_in}; // RULE_01
        end else begin
            stamp = {{TIMER_W{1'b0}}, third_timer_in}; // RULE_01
        end

        // edges come from the filtered level, so a glitch shorter than
        // two cycles never reaches the mode decoder
        case (ctrl.mode)
            ICF_MODE_EDGE:   capture_hit = pin_change; // RULE_11 RULE_16
            ICF_MODE_FALL:   capture_hit = pin_fall; // RULE_10
            ICF_MODE_RISE:   capture_hit = pin_rise; // RULE_09
            ICF_MODE_RISE4:  capture_hit = pin_rise && (prescale[1:0] == 2'h3); // RULE_08
            ICF_MODE_RISE16: capture_hit = pin_rise && (prescale == 4'hF); // RULE_07
            ICF_MODE_EVERY:  begin
                if (first_done) begin
                    capture_hit = pin_change; // RULE_06
                end else begin
                    capture_hit = ctrl.first_rise ? pin_rise : pin_fall; // RULE_06
                end
            end
            default:         capture_hit = 1'b0; // RULE_12 RULE_15
        endcase
        capture_hit = capture_hit && ctrl.on;

        // prescaler counts rising edges in every mode, disabled included
        if (ctrl.on && pin_rise) begin
            next_prescale = prescale + 4'h1; // RULE_15
        end

        // mode 110 re-arms its first edge whenever it is left
        if (!ctrl.on || ctrl.mode != ICF_MODE_EVERY) begin
            next_first_done = 1'b0;
        end else if (capture_hit) begin
            next_first_done = 1'b1;
        end

        // a read of the result buffer pops the oldest value
        pop      = rd_en_in && (addr_in == ICF_ADDR_BUFFER) && (fill != '0);
        full_now = (fill == FULL_CNT) && !pop;
        if (pop) begin
            next_rd_ptr = (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + PTR_W'(1);
        end
        if (capture_hit) begin
            if (full_now) begin
                next_overflow               = 1'b1; // RULE_17
                irq_set[ICF_IRQ_OVERFLOW]   = 1'b1;
            end else begin
                push                  = 1'b1;
                next_fifo_mem[wr_ptr] = stamp;
                next_wr_ptr = (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + PTR_W'(1);
                if (event_cnt == ctrl.irq_interval) begin
                    next_event_cnt           = 2'h0; // RULE_02
                    irq_set[ICF_IRQ_CAPTURE] = 1'b1;
                end else begin
                    next_event_cnt = event_cnt + 2'h1; // RULE_02
                end
            end
        end
        // a pop and a push in one cycle leave the fill count as it was
        if (push && !pop) begin
            next_fill = fill + CNT_W'(1);
        end else if (pop && !push) begin
            next_fill = fill - CNT_W'(1);
        end

        // interrupt-only: wake on a rising edge while asleep or idle
        if (ctrl.on && ctrl.mode == ICF_MODE_IRQ_ONLY && low_power_in && pin_rise) begin
            irq_set[ICF_IRQ_CAPTURE] = 1'b1; // RULE_05
        end

        // register writes
        if (wr_en_in) begin
            if (addr_in == ICF_ADDR_CONTROL) begin
                // bits 4 and 3 are status, so a control write never reaches them
                next_ctrl.on           = wr_data_in[ICF_BIT_ON];
                next_ctrl.first_rise   = wr_data_in[ICF_BIT_FIRST_EDGE];
                next_ctrl.wide         = wr_data_in[ICF_BIT_WIDE];
                next_ctrl.timer_sel    = wr_data_in[ICF_BIT_TIMER_SEL];
                next_ctrl.irq_interval = wr_data_in[ICF_BIT_IRQ_HI:ICF_BIT_IRQ_LO];
                next_ctrl.mode         = wr_data_in[ICF_BIT_MODE_HI:ICF_BIT_MODE_LO];
            end else if (addr_in == ICF_ADDR_CLEAR) begin
                irq_clr = wr_data_in[ICF_IRQ_W-1:0];
            end else if (addr_in == ICF_ADDR_ENABLE) begin
                next_irq_enable = wr_data_in[ICF_IRQ_W-1:0];
            end
        end

        // disabled unit holds its counters and buffer in reset
        if (!ctrl.on) begin
            next_overflow  = 1'b0; // RULE_14
            next_wr_ptr    = '0; // RULE_14
            next_rd_ptr    = '0; // RULE_14
            next_fill      = '0; // RULE_14
            next_event_cnt = 2'h0; // RULE_14
            next_prescale  = ICF_RST_PRE; // RULE_14
        end

        // set wins over a clear in the same cycle
        next_irq_status = (irq_status & ~irq_clr) | irq_set;
        // built from next values so irq_out rises with its status bit
        next_irq        = |(next_irq_status & next_irq_enable);

        ctrl_word                                   = 32'h0;
        ctrl_word[ICF_BIT_ON]                       = ctrl.on;
        ctrl_word[ICF_BIT_FIRST_EDGE]               = ctrl.first_rise;
        ctrl_word[ICF_BIT_WIDE]                     = ctrl.wide;
        ctrl_word[ICF_BIT_TIMER_SEL]                = ctrl.timer_sel;
        ctrl_word[ICF_BIT_IRQ_HI:ICF_BIT_IRQ_LO]    = ctrl.irq_interval;
        ctrl_word[ICF_BIT_OVERFLOW]                 = overflow; // RULE_03
        ctrl_word[ICF_BIT_NONEMPTY]                 = (fill != '0); // RULE_04
        ctrl_word[ICF_BIT_MODE_HI:ICF_BIT_MODE_LO]  = ctrl.mode;

        // unmapped addresses and an empty buffer read as zero
        next_rd_data = 32'h0;
        if (rd_en_in) begin
            if (addr_in == ICF_ADDR_CONTROL) begin
                next_rd_data = ctrl_word;
            end else if (addr_in == ICF_ADDR_BUFFER) begin
                next_rd_data = pop ? 32'(fifo_mem[rd_ptr]) : 32'h0;
            end else if (addr_in == ICF_ADDR_STATUS) begin
                next_rd_data = {{(32-ICF_IRQ_W){1'b0}}, irq_status};
            end else if (addr_in == ICF_ADDR_ENABLE) begin
                next_rd_data = {{(32-ICF_IRQ_W){1'b0}}, irq_enable};
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl        <= ICF_RST_CTRL;
            overflow    <= 1'b0;
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            fill        <= '0;
            prescale    <= ICF_RST_PRE;
            event_cnt   <= 2'h0;
            first_done  <= 1'b0;
            irq_status  <= ICF_RST_IRQ;
            irq_enable  <= ICF_RST_IRQ;
            rd_data_out <= 32'h0;
            irq_out     <= 1'b0;
        end else if (ce_in) begin
            ctrl        <= next_ctrl;
            overflow    <= next_overflow;
            wr_ptr      <= next_wr_ptr;
            rd_ptr      <= next_rd_ptr;
            fill        <= next_fill;
            prescale    <= next_prescale;
            event_cnt   <= next_event_cnt;
            first_done  <= next_first_done;
            irq_status  <= next_irq_status;
            irq_enable  <= next_irq_enable;
            rd_data_out <= next_rd_data;
            irq_out     <= next_irq;
        end
    end

    // buffer storage has no reset; only pointers define its content
    always_ff @(posedge clk_in) begin
        if (ce_in) begin
            fifo_mem <= next_fifo_mem;
        end
    end

endmodule // icf_capture

`default_nettype wire

/* File: hdl/icf_pkg.sv */
// icf_pkg: constants and types for the input capture control block.
// assumes one 10 MHz clock and a byte-addressed plain register port.
package icf_pkg;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] ICF_ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ICF_ADDR_BUFFER  = 8'h04;
    localparam logic [7:0] ICF_ADDR_STATUS  = 8'h08;
    localparam logic [7:0] ICF_ADDR_CLEAR   = 8'h0C;
    localparam logic [7:0] ICF_ADDR_ENABLE  = 8'h10;

    // ==========================================================
    // capture_control field positions
    localparam int ICF_BIT_ON         = 15;
    localparam int ICF_BIT_FIRST_EDGE = 9;
    localparam int ICF_BIT_WIDE       = 8;
    localparam int ICF_BIT_TIMER_SEL  = 7;
    localparam int ICF_BIT_IRQ_HI     = 6;
    localparam int ICF_BIT_IRQ_LO     = 5;
    localparam int ICF_BIT_OVERFLOW   = 4;
    localparam int ICF_BIT_NONEMPTY   = 3;
    localparam int ICF_BIT_MODE_HI    = 2;
    localparam int ICF_BIT_MODE_LO    = 0;

    // interrupt status / clear / enable bits
    localparam int ICF_IRQ_CAPTURE  = 0;
    localparam int ICF_IRQ_OVERFLOW = 1;
    localparam int ICF_IRQ_W        = 2;

    // ==========================================================
    // capture_mode_select codes
    localparam logic [2:0] ICF_MODE_OFF      = 3'h0;
    localparam logic [2:0] ICF_MODE_EDGE     = 3'h1;
    localparam logic [2:0] ICF_MODE_FALL     = 3'h2;
    localparam logic [2:0] ICF_MODE_RISE     = 3'h3;
    localparam logic [2:0] ICF_MODE_RISE4    = 3'h4;
    localparam logic [2:0] ICF_MODE_RISE16   = 3'h5;
    localparam logic [2:0] ICF_MODE_EVERY    = 3'h6;
    localparam logic [2:0] ICF_MODE_IRQ_ONLY = 3'h7;

    // ==========================================================
    // reset values
    localparam logic [ICF_IRQ_W-1:0] ICF_RST_IRQ = 2'h0;
    localparam logic [3:0]           ICF_RST_PRE = 4'h0;

    typedef struct packed {
        logic       on;
        logic       first_rise;
        logic       wide;
        logic       timer_sel;
        logic [1:0] irq_interval;
        logic [2:0] mode;
    } icf_ctrl_t;

    localparam icf_ctrl_t ICF_RST_CTRL = '{on: 1'b0, first_rise: 1'b0, wide: 1'b0,
                                          timer_sel: 1'b0, irq_interval: 2'h0,
                                          mode: 3'h0};

endpackage

/* File: tb/icf_capture_properties.sv */
// icf_capture_properties: port checks for icf_capture, bound in below.
// assumes ce_in stays high; shadows follow control and enable writes.
`timescale 1ns/1ps
`default_nettype none
module icf_capture_properties
    import icf_pkg::*;
(
    // clock and reset
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    // register port and interrupt
    input wire logic [7:0]  addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic        wr_en_in,
    input wire logic        rd_en_in,
    input wire logic [31:0] rd_data_out,
    input wire logic        irq_out
);
    logic [15:0] ctl_w;
    logic [1:0]  en_w;
    wire logic   rd_ctl = rd_en_in && addr_in == ICF_ADDR_CONTROL;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // ==========================================
    // shadows; bits 14:10 and 4:3 are never stored
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctl_w <= 16'h0000;
            en_w  <= 2'h0;
        end else if (wr_en_in && addr_in == ICF_ADDR_CONTROL) begin
            ctl_w <= wr_data_in[15:0] & 16'h83E7;
        end else if (wr_en_in && addr_in == ICF_ADDR_ENABLE) begin
            en_w <= wr_data_in[1:0];
        end
    end
    // ==========================================
    // checks
    ctrl_fields_a:
        assert property (rd_ctl |=> (rd_data_out & 32'hFFFF_FFE7) == {16'h0, ctl_w})
        else $error("control readback wrong");
    off_flags_a:
        assert property (rd_ctl && !ctl_w[15] && !$past(ctl_w[15]) |=> rd_data_out[4:3] == 2'h0)
        else $error("status flags set while off");
    unmapped_read_a:
        assert property (rd_en_in && addr_in > ICF_ADDR_ENABLE |=> rd_data_out == 32'h0)
        else $error("unmapped read not zero");
    status_width_a:
        assert property (rd_en_in && addr_in == ICF_ADDR_STATUS |=> rd_data_out[31:2] == 30'h0)
        else $error("status upper bits set");
    enable_read_a:
        assert property (rd_en_in && addr_in == ICF_ADDR_ENABLE |=> rd_data_out == {30'h0, en_w})
        else $error("enable readback wrong");
    irq_mask_a:
        assert property (en_w == 2'h0 && $past(en_w) == 2'h0 |-> !irq_out)
        else $error("interrupt while masked");
    read_idle_a:
        assert property (!$past(rd_en_in) |-> rd_data_out == 32'h0)
        else $error("read data outside read cycle");
    reset_quiet_a:
        assert property ($rose(rst_n_in) |-> !irq_out && rd_data_out == 32'h0)
        else $error("outputs active after reset");
    cover property (rd_en_in && addr_in == ICF_ADDR_BUFFER ##1 rd_data_out != 32'h0);
    cover property ($rose(irq_out));
    cover property (rd_ctl ##1 rd_data_out[4]);
endmodule // icf_capture_properties
bind icf_capture icf_capture_properties chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .irq_out(irq_out));
`default_nettype wire

/* File: tb/icf_pin_model.sv */
// icf_pin_model: far side of the capture unit, input pin and two timers.
// assumes one clock; the pin moves only when the bench asks.
`timescale 1ns/1ps
`default_nettype none
module icf_pin_model (
    // clock
    input  wire logic   clk_in,
    // pin and timer counts
    output logic        pin_out,
    output logic [15:0] second_out,
    output logic [15:0] third_out
);
    initial pin_out = 1'b0;
    initial second_out = 16'h1234;
    // inverted copy so a captured value tells which timer it came from
    assign third_out = ~second_out;
    always @(posedge clk_in) second_out <= second_out + 16'h0001;
    task automatic set_pin(input logic lvl);
        @(posedge clk_in);
        pin_out <= lvl;
    endtask
endmodule // icf_pin_model
`default_nettype wire

/* File: tb/input_capture_control_fields_tb.sv */
// input_capture_control_fields_tb: self-checking bench for icf_capture.
// assumes icf_pin_model drives the pin and both timer counts.
`timescale 1ns/1ps
`default_nettype none
module input_capture_control_fields_tb
    import icf_pkg::*;
;
    localparam logic [31:0] ON = 32'h0000_8000;
    logic clk_in = 1'b0, rst_n_in = 1'b0, we = 1'b0, re = 1'b0, lp = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic        irq, pin, sel;
    logic [15:0] t2, t3, t0;
    int          fails = 0, checked = 0, n;
    logic [2:0]  modes [9] = '{ICF_MODE_OFF, ICF_MODE_EDGE, ICF_MODE_FALL, ICF_MODE_RISE,
        ICF_MODE_RISE4, ICF_MODE_RISE16, ICF_MODE_EVERY, ICF_MODE_EVERY, ICF_MODE_IRQ_ONLY};
    always #50 clk_in = ~clk_in;
    icf_capture uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .addr_in(addr),
        .wr_data_in(wdata), .wr_en_in(we), .rd_en_in(re), .rd_data_out(rdata),
        .cap_pin_in(pin), .second_timer_in(t2), .third_timer_in(t3), .low_power_in(lp),
        .irq_out(irq));
    icf_pin_model src (.clk_in(clk_in), .pin_out(pin), .second_out(t2), .third_out(t3));
    // ==========================================
    // expectations and checking
    // 32 toggles from low give 16 rising and 16 falling edges
    function automatic int exp_caps(input logic [2:0] m, input bit fr);
        case (m)
            ICF_MODE_EDGE: return 32;
            ICF_MODE_FALL, ICF_MODE_RISE: return 16;
            ICF_MODE_RISE4: return 4;
            ICF_MODE_RISE16: return 1;
            ICF_MODE_EVERY: return fr ? 32 : 31;
            default: return 0;
        endcase
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ==========================================
    // register port and pin traffic
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk_in);
        we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        addr <= a;
        re <= 1'b1;
        @(posedge clk_in);
        re <= 1'b0;
        @(negedge clk_in);
        d = rdata;
    endtask
    task automatic restart(input logic [31:0] ctl);
        wr(ICF_ADDR_CONTROL, 32'h0);
        wr(ICF_ADDR_CLEAR, 32'h3);
        wr(ICF_ADDR_CONTROL, ctl);
        n = 0;
        sel = ctl[ICF_BIT_TIMER_SEL];
    endtask
    // pops until empty; timed pops must hold a count taken just after the last toggle
    task automatic drain(input bit timed);
        logic [15:0] d;
        for (int i = 0; i < 6; i++) begin
            rd(ICF_ADDR_CONTROL, v);
            if (!v[3]) break;
            rd(ICF_ADDR_BUFFER, v);
            n++;
            d = (sel ? v[15:0] : ~v[15:0]) - t0;
            if (timed) check("capture time", {31'h0, d >= 16'h1 && d <= 16'hA}, 32'h1);
        end
    endtask
    task automatic edges(input int cnt, input bit pop);
        for (int i = 0; i < cnt; i++) begin
            src.set_pin(!pin);
            t0 = t2;
            repeat (8 + $urandom % 3) @(posedge clk_in);
            if (pop) drain(1'b1);
        end
    endtask
    task automatic irq_is(input string what, input logic exp);
        repeat (2) @(negedge clk_in);
        check(what, irq, exp);
    endtask
    initial begin
        #2_000_000;
        fails++;
        report_and_stop;
    end
    initial begin
        void'($urandom(32'h70DA));
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(ICF_ADDR_CONTROL, v);
        check("control at reset", v, 32'h0);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, v);
        check("unmapped read", v, 32'h0);
        wr(ICF_ADDR_ENABLE, 32'h3);
        $display("test reset done");
        foreach (modes[i]) begin
            sel = 1'($urandom % 2);
            restart(ON | {22'h0, i == 6, 1'b0, sel, 4'h0, modes[i]});
            edges(32, 1'b1);
            check("capture count", n, exp_caps(modes[i], i == 6));
        end
        $display("test modes done");
        restart(ON | ICF_MODE_RISE4);
        wr(ICF_ADDR_CONTROL, ON);
        edges(4, 1'b0);
        wr(ICF_ADDR_CONTROL, ON | ICF_MODE_RISE4);
        edges(4, 1'b1);
        check("prescale across disable", n, 1);
        $display("test prescaler done");
        for (int iv = 0; iv < 4; iv++) begin
            restart(ON | {iv[1:0], 5'h0} | ICF_MODE_RISE);
            for (int k = 0; k <= iv; k++) begin
                edges(2, 1'b1);
                rd(ICF_ADDR_STATUS, v);
                check("interval event", v[0], k == iv);
            end
            irq_is("irq raised", 1'b1);
            wr(ICF_ADDR_ENABLE, 32'h0);
            irq_is("irq masked", 1'b0);
            wr(ICF_ADDR_ENABLE, 32'h3);
            irq_is("irq unmasked", 1'b1);
            wr(ICF_ADDR_CLEAR, 32'h1);
            irq_is("irq cleared", 1'b0);
        end
        $display("test interval done");
        restart(ON | ICF_MODE_RISE);
        edges(10, 1'b0);
        wr(ICF_ADDR_CONTROL, ON | ICF_MODE_RISE);
        rd(ICF_ADDR_CONTROL, v);
        check("full flags", v[4:3], 2'h3);
        rd(ICF_ADDR_STATUS, v);
        check("overflow event", v[1], 1'b1);
        drain(1'b0);
        check("values kept", n, 4);
        rd(ICF_ADDR_CONTROL, v);
        check("overflow sticky", v[4:3], 2'h2);
        rd(ICF_ADDR_BUFFER, v);
        check("empty pop", v, 32'h0);
        wr(ICF_ADDR_CONTROL, ICF_MODE_RISE);
        rd(ICF_ADDR_CONTROL, v);
        check("flags after off", v[4:3], 2'h0);
        $display("test overflow done");
        restart(ON | 32'h100 | ICF_MODE_RISE);
        edges(1, 1'b0);
        rd(ICF_ADDR_BUFFER, v);
        check("wide halves", v, {~v[15:0], v[15:0]});
        check("wide low half", {31'h0, 16'(v[15:0] - t0 - 16'h1) < 16'hA}, 32'h1);
        edges(1, 1'b0);
        $display("test wide done");
        @(posedge clk_in);
        lp <= 1'b1;
        restart(ON | ICF_MODE_IRQ_ONLY);
        edges(2, 1'b0);
        rd(ICF_ADDR_STATUS, v);
        check("wake event", v[0], 1'b1);
        rd(ICF_ADDR_CONTROL, v);
        check("no value kept", v[3], 1'b0);
        $display("test low power done");
        report_and_stop;
    end
endmodule // input_capture_control_fields_tb
`default_nettype wire
